// file: design/vred_detector.sv
// ventricular rhythm episode detector with apb register file
// Notes on behaviour
// R1: fast counter counts up on fast intervals, down on slower ones
// R2: interference clears the fast counter
// R3: counter reaching the set count declares a fast episode, starts recording
// R4: fast episode ends after five consecutive slower intervals
// R5: noise never counts toward or ends fast termination
// R6: beat followed by noise marker is interference, clearing the counter
// R7: fast limit defaults to 180 bpm; interval count never below 8
// R8: each episode type has an enable; cleared means no detection at all
// R9: slow detection starts when rate falls below zone limit, default 40
// R10: slow episode confirmed when below-limit run exceeds duration, default 10 s
// R11: noise drops newest and oldest interval; confirm only if total exceeds
// R12: slow termination counter cleared on detection, counts short, ends at 10
// R13: noise sets slow termination counter to one, never below zero
// R14: sudden drop compares baseline mean rate with rate-drop mean rate
// R15: baseline count 48, 64, 128 or 256; presets 256, 64, 48
// R16: rate-drop count 8, 16 or 32; presets 32, 16, 8
// R17: counts off the presets report custom sensitivity
// R18: noise resets both sudden-drop windows
// R19: sudden drop has no termination, reported after the decrease
// R20: asystole when a beat-to-beat interval exceeds the set duration
// R21: asystole ignores noise, no termination
// R22: intervals counted in millisecond ticks, compared via rate products
// R23: front end gives one-cycle marker pulses, one per cycle at most
`timescale 1ns/1ns
`include "vred_map.svh"
module vred_detector #(
  parameter int TICK_CYCLES = `VRED_TICK_NS / `VRED_CLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input vred_pkg::vred_addr_t paddr,
  input vred_pkg::vred_word_t pwdata,
  output vred_pkg::vred_word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sensed_beat_marker,
  input wire logic noise_window_marker,
  output logic fast_rate_episode,
  output logic fast_rate_rec,
  output logic slow_rate_episode,
  output logic slow_rate_rec,
  output logic sudden_drop_episode,
  output logic asystole_episode
);
  import vred_pkg::*;

  function automatic logic [8:0] base_len(input logic [1:0] s);
    case (s)
      `VRED_BSEL_48: base_len = 9'd48;
      `VRED_BSEL_64: base_len = 9'd64;
      `VRED_BSEL_128: base_len = 9'd128;
      default: base_len = 9'd256;
    endcase
  endfunction : base_len

  function automatic logic [8:0] drop_len(input logic [1:0] s);
    case (s)
      `VRED_DSEL_8: drop_len = 9'd8;
      `VRED_DSEL_16: drop_len = 9'd16;
      default: drop_len = 9'd32;
    endcase
  endfunction : drop_len

  // rate of interval iv against bpm: -1 slower, 0 equal, 1 faster
  function automatic logic [1:0] rate_cmp(input logic [15:0] iv,
                                          input logic [7:0] bpm);
    logic [23:0] p;
    p = 24'(iv) * 24'(bpm);
    if (p < `VRED_MS_PER_MIN) rate_cmp = 2'b01;
    else if (p == `VRED_MS_PER_MIN) rate_cmp = 2'b00;
    else rate_cmp = 2'b11;
  endfunction : rate_cmp

  logic [3:0] ctrl_ff;
  logic [7:0] fast_bpm_ff, slow_bpm_ff;
  logic [5:0] fast_num_ff;
  logic [4:0] slow_dur_ff;
  logic [6:0] drop_pct_ff;
  logic [1:0] bsel_ff, dsel_ff, sens_rd;
  logic [3:0] asys_s_ff;
  logic drop_seen_ff, asys_seen_ff;
  logic pready_ff, pslverr_ff;
  vred_word_t prdata_ff, nxt_prdata;
  logic hit, wr_en, cfg_drop_wr;
  logic [5:0] fast_cnt_ff;
  logic [3:0] term_ff;

  // one wait state: the answer comes on the second access cycle
  always_comb begin
    hit = 1'b1;
    nxt_prdata = '0;
    sens_rd = `VRED_SENS_CUST; // see R17
    if (bsel_ff == `VRED_BSEL_256 && dsel_ff == `VRED_DSEL_32)
      sens_rd = `VRED_SENS_LOW; // see R15, R16
    else if (bsel_ff == `VRED_BSEL_64 && dsel_ff == `VRED_DSEL_16)
      sens_rd = `VRED_SENS_MED;
    else if (bsel_ff == `VRED_BSEL_48 && dsel_ff == `VRED_DSEL_8)
      sens_rd = `VRED_SENS_HIGH;
    case (paddr)
      `VRED_A_CTRL: nxt_prdata[`VRED_F_EN] = ctrl_ff;
      `VRED_A_FAST: begin
        nxt_prdata[`VRED_F_BPM] = fast_bpm_ff;
        nxt_prdata[`VRED_F_FNUM] = fast_num_ff;
      end
      `VRED_A_SLOW: begin
        nxt_prdata[`VRED_F_BPM] = slow_bpm_ff;
        nxt_prdata[`VRED_F_SDUR] = slow_dur_ff;
      end
      `VRED_A_DROP: begin
        nxt_prdata[`VRED_F_PCT] = drop_pct_ff;
        nxt_prdata[`VRED_F_BSEL] = bsel_ff;
        nxt_prdata[`VRED_F_DSEL] = dsel_ff;
        nxt_prdata[`VRED_F_SENSRD] = sens_rd;
      end
      `VRED_A_SENS: nxt_prdata[`VRED_F_SENS] = sens_rd;
      `VRED_A_ASYS: nxt_prdata[`VRED_F_ASYS] = asys_s_ff;
      `VRED_A_STAT: begin
        nxt_prdata[`VRED_EN_FAST] = fast_rate_episode;
        nxt_prdata[`VRED_EN_SLOW] = slow_rate_episode;
        nxt_prdata[`VRED_F_DSEEN] = drop_seen_ff;
        nxt_prdata[`VRED_F_ASEEN] = asys_seen_ff;
        nxt_prdata[`VRED_F_FCNT] = fast_cnt_ff;
        nxt_prdata[`VRED_F_TERM] = term_ff;
      end
      default: hit = 1'b0;
    endcase
  end

  assign wr_en = psel & penable & pwrite & pready_ff & hit;
  assign cfg_drop_wr = wr_en &&
    (paddr == `VRED_A_DROP || paddr == `VRED_A_SENS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= psel & penable & ~pready_ff;
      pslverr_ff <= psel & penable & ~pready_ff & ~hit;
      if (psel & penable & ~pready_ff & ~pwrite) prdata_ff <= nxt_prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `VRED_CTRL_RST;
      fast_bpm_ff <= `VRED_FAST_BPM_RST; // see R7
      fast_num_ff <= `VRED_FAST_NUM_RST;
      slow_bpm_ff <= `VRED_SLOW_BPM_RST; // see R9
      slow_dur_ff <= `VRED_SLOW_DUR_RST; // see R10
      drop_pct_ff <= `VRED_DROP_PCT_RST;
      bsel_ff <= `VRED_BSEL_64;
      dsel_ff <= `VRED_DSEL_16;
      asys_s_ff <= `VRED_ASYS_RST;
    end else if (wr_en) begin
      case (paddr)
        `VRED_A_CTRL: ctrl_ff <= pwdata[`VRED_F_EN];
        `VRED_A_FAST: begin
          fast_bpm_ff <= pwdata[`VRED_F_BPM];
          // a count below the floor is raised to it
          fast_num_ff <= (pwdata[`VRED_F_FNUM] < `VRED_FAST_NUM_MIN) ?
            `VRED_FAST_NUM_MIN : pwdata[`VRED_F_FNUM]; // see R7
        end
        `VRED_A_SLOW: begin
          slow_bpm_ff <= pwdata[`VRED_F_BPM];
          slow_dur_ff <= pwdata[`VRED_F_SDUR];
        end
        `VRED_A_DROP: begin
          drop_pct_ff <= pwdata[`VRED_F_PCT];
          bsel_ff <= pwdata[`VRED_F_BSEL];
          dsel_ff <= (pwdata[`VRED_F_DSEL] > `VRED_DSEL_32) ?
            `VRED_DSEL_32 : pwdata[`VRED_F_DSEL]; // see R16
        end
        `VRED_A_SENS: begin
          case (pwdata[`VRED_F_SENS])
            `VRED_SENS_LOW: begin
              bsel_ff <= `VRED_BSEL_256; // see R15
              dsel_ff <= `VRED_DSEL_32; // see R16
            end
            `VRED_SENS_MED: begin
              bsel_ff <= `VRED_BSEL_64;
              dsel_ff <= `VRED_DSEL_16;
            end
            `VRED_SENS_HIGH: begin
              bsel_ff <= `VRED_BSEL_48;
              dsel_ff <= `VRED_DSEL_8;
            end
            default: ;
          endcase
        end
        `VRED_A_ASYS: asys_s_ff <= pwdata[`VRED_F_ASYS];
        default: ;
      endcase
    end
  end

  // millisecond tick and beat interval measurement
  logic [16:0] tick_cnt_ff;
  logic tick_ff, seen_ff, beat_iv_v;
  logic [15:0] iv_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (tick_cnt_ff == 17'(TICK_CYCLES - 1));
      if (tick_cnt_ff == 17'(TICK_CYCLES - 1)) tick_cnt_ff <= '0;
      else tick_cnt_ff <= tick_cnt_ff + 17'h1;
    end
  end

  // noise does not restart the interval: only beat to beat counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iv_ff <= '0;
      seen_ff <= 1'b0;
    end else if (sensed_beat_marker) begin
      iv_ff <= '0; // see R22, R21
      seen_ff <= 1'b1;
    end else if (tick_ff && iv_ff != 16'hffff) begin
      iv_ff <= iv_ff + 16'h1;
    end
  end
  assign beat_iv_v = sensed_beat_marker & seen_ff;

  // fast rate detection
  vred_state_t fast_st_ff;
  logic [2:0] fast_low_ff;
  logic [1:0] fast_cmp;
  logic fast_rec_ff, fast_iv;
  assign fast_cmp = rate_cmp(iv_ff, fast_bpm_ff);
  assign fast_iv = ~fast_cmp[1]; // rate at or above
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_st_ff <= VRED_IDLE;
      fast_cnt_ff <= '0;
      fast_low_ff <= '0;
      fast_rec_ff <= 1'b0;
    end else if (!ctrl_ff[`VRED_EN_FAST]) begin
      fast_st_ff <= VRED_IDLE; // see R8
      fast_cnt_ff <= '0;
      fast_low_ff <= '0;
      fast_rec_ff <= 1'b0;
    end else begin
      fast_rec_ff <= 1'b0;
      if (noise_window_marker) begin
        fast_cnt_ff <= '0; // see R2, R5, R6
      end else if (beat_iv_v) begin
        case (fast_st_ff)
          VRED_IDLE: begin
            if (fast_iv && fast_cnt_ff + 6'h1 >= fast_num_ff) begin
              fast_st_ff <= VRED_EPI; // see R3
              fast_rec_ff <= 1'b1;
              fast_cnt_ff <= '0;
              fast_low_ff <= '0;
            end else if (fast_iv) begin
              fast_cnt_ff <= fast_cnt_ff + 6'h1; // see R1
            end else if (fast_cnt_ff != 6'h0) begin
              fast_cnt_ff <= fast_cnt_ff - 6'h1; // see R1
            end
          end
          VRED_EPI: begin
            if (fast_iv) fast_low_ff <= '0;
            else if (fast_low_ff == `VRED_FAST_END) begin
              fast_st_ff <= VRED_IDLE; // see R4
              fast_low_ff <= '0;
            end else fast_low_ff <= fast_low_ff + 3'h1;
          end
          default: fast_st_ff <= VRED_IDLE;
        endcase
      end
    end
  end

  // slow rate detection: run of below-limit intervals in a ring
  vred_state_t slow_st_ff;
  logic [15:0] smem [64];
  logic [5:0] shead_ff, stail_ff;
  logic [6:0] sfill_ff;
  logic [20:0] ssum_ff, ssum_push, dur_ms;
  logic slow_rec_ff, slow_below, slow_push;
  logic [1:0] slow_cmp;
  assign slow_cmp = rate_cmp(iv_ff, slow_bpm_ff);
  assign slow_below = (slow_cmp == 2'b11); // see R9
  assign ssum_push = ssum_ff + 21'(iv_ff);
  assign dur_ms = 21'(slow_dur_ff) * 21'(`VRED_MS_PER_S);
  assign slow_push = ctrl_ff[`VRED_EN_SLOW] && slow_st_ff == VRED_IDLE &&
    beat_iv_v && slow_below;
  always_ff @(posedge pclk) begin
    if (slow_push) smem[shead_ff] <= iv_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_st_ff <= VRED_IDLE;
      shead_ff <= '0;
      stail_ff <= '0;
      sfill_ff <= '0;
      ssum_ff <= '0;
      term_ff <= '0;
      slow_rec_ff <= 1'b0;
    end else if (!ctrl_ff[`VRED_EN_SLOW]) begin
      slow_st_ff <= VRED_IDLE; // see R8
      stail_ff <= shead_ff;
      sfill_ff <= '0;
      ssum_ff <= '0;
      term_ff <= '0;
      slow_rec_ff <= 1'b0;
    end else begin
      slow_rec_ff <= 1'b0;
      case (slow_st_ff)
        VRED_IDLE: begin
          if (noise_window_marker && sfill_ff >= 7'h2) begin
            shead_ff <= shead_ff - 6'h1; // see R11
            stail_ff <= stail_ff + 6'h1;
            sfill_ff <= sfill_ff - 7'h2;
            ssum_ff <= ssum_ff - 21'(smem[shead_ff - 6'h1]) -
              21'(smem[stail_ff]);
          end else if (noise_window_marker || (beat_iv_v && !slow_below)) begin
            stail_ff <= shead_ff;
            sfill_ff <= '0;
            ssum_ff <= '0;
          end else if (slow_push) begin
            shead_ff <= shead_ff + 6'h1;
            if (ssum_push > dur_ms) begin
              slow_st_ff <= VRED_EPI; // see R10
              slow_rec_ff <= 1'b1;
              term_ff <= '0; // see R12
              stail_ff <= shead_ff + 6'h1;
              sfill_ff <= '0;
              ssum_ff <= '0;
            end else if (sfill_ff == `VRED_SMEM_FULL) begin
              // ring full: oldest falls out, run total stays a lower bound
              stail_ff <= stail_ff + 6'h1;
              ssum_ff <= ssum_push - 21'(smem[stail_ff]);
            end else begin
              sfill_ff <= sfill_ff + 7'h1;
              ssum_ff <= ssum_push;
            end
          end
        end
        VRED_EPI: begin
          if (noise_window_marker) term_ff <= 4'h1; // see R13
          else if (beat_iv_v && slow_cmp == 2'b01) begin
            if (term_ff == `VRED_SLOW_END) begin
              slow_st_ff <= VRED_IDLE; // see R12
              term_ff <= '0;
            end else term_ff <= term_ff + 4'h1; // see R12
          end else if (beat_iv_v && slow_cmp == 2'b11) term_ff <= '0;
        end
        default: slow_st_ff <= VRED_IDLE;
      endcase
    end
  end

  // sudden drop: sliding rate-drop window fed into baseline window
  logic [15:0] dmem [512];
  logic [8:0] dhead_ff, nb, nd;
  logic [9:0] dfill_ff, dwin;
  logic [23:0] sb_ff, sb_n;
  logic [20:0] sd_ff, sd_n;
  logic [15:0] mid_iv, old_iv;
  logic [39:0] lhs, rhs;
  logic drop_push, drop_hit, drop_ff;
  assign nb = base_len(bsel_ff);
  assign nd = drop_len(dsel_ff);
  assign dwin = 10'(nb) + 10'(nd);
  assign drop_push = ctrl_ff[`VRED_EN_DROP] && beat_iv_v && !cfg_drop_wr;
  assign mid_iv = (dfill_ff >= 10'(nd)) ? dmem[dhead_ff - nd] : 16'h0;
  assign old_iv = (dfill_ff >= dwin) ? dmem[dhead_ff - nd - nb] : 16'h0;
  assign sd_n = sd_ff + 21'(iv_ff) - 21'(mid_iv);
  assign sb_n = sb_ff + 24'(mid_iv) - 24'(old_iv);
  // drop mean rate below (100 - pct) percent of baseline mean rate
  assign lhs = 40'(nd) * 40'(sb_n) * 40'(`VRED_PCT_FULL);
  assign rhs = 40'(`VRED_PCT_FULL - drop_pct_ff) * 40'(nb) * 40'(sd_n);
  assign drop_hit = (dfill_ff + 10'h1 >= dwin) && (lhs < rhs); // see R14
  always_ff @(posedge pclk) begin
    if (drop_push) dmem[dhead_ff] <= iv_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dhead_ff <= '0;
      dfill_ff <= '0;
      sb_ff <= '0;
      sd_ff <= '0;
      drop_ff <= 1'b0;
    end else if (!ctrl_ff[`VRED_EN_DROP] || noise_window_marker ||
                 cfg_drop_wr) begin
      dfill_ff <= '0; // see R18, R8
      sb_ff <= '0;
      sd_ff <= '0;
      drop_ff <= 1'b0;
    end else begin
      drop_ff <= 1'b0;
      if (drop_push && drop_hit) begin
        // no termination: windows restart so one drop reports once
        drop_ff <= 1'b1; // see R19
        dfill_ff <= '0;
        sb_ff <= '0;
        sd_ff <= '0;
        dhead_ff <= dhead_ff + 9'h1;
      end else if (drop_push) begin
        dhead_ff <= dhead_ff + 9'h1;
        sd_ff <= sd_n;
        sb_ff <= sb_n;
        if (dfill_ff < dwin) dfill_ff <= dfill_ff + 10'h1;
      end
    end
  end

  // asystole and sticky status; a new event beats a clear
  logic asys_ff, asys_hit;
  assign asys_hit = ctrl_ff[`VRED_EN_ASYS] && beat_iv_v &&
    iv_ff > 16'(asys_s_ff) * `VRED_MS_PER_S; // see R20, R21
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      asys_ff <= 1'b0;
      asys_seen_ff <= 1'b0;
      drop_seen_ff <= 1'b0;
    end else begin
      asys_ff <= asys_hit;
      if (asys_hit) asys_seen_ff <= 1'b1;
      else if (wr_en && paddr == `VRED_A_STAT && pwdata[`VRED_F_ASEEN])
        asys_seen_ff <= 1'b0;
      if (drop_push && drop_hit) drop_seen_ff <= 1'b1;
      else if (wr_en && paddr == `VRED_A_STAT && pwdata[`VRED_F_DSEEN])
        drop_seen_ff <= 1'b0;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign fast_rate_episode = fast_st_ff[1];
  assign fast_rate_rec = fast_rec_ff;
  assign slow_rate_episode = slow_st_ff[1];
  assign slow_rate_rec = slow_rec_ff;
  assign sudden_drop_episode = drop_ff;
  assign asystole_episode = asys_ff;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  fast_clear_a: assert property ( // see R2
    ctrl_ff[`VRED_EN_FAST] && noise_window_marker |=> fast_cnt_ff == 6'h0)
    else $error("fast counter not cleared by noise");
  fast_declare_a: assert property ( // see R3
    $rose(fast_rate_episode) |-> fast_rate_rec &&
    $past(fast_cnt_ff) + 6'h1 >= $past(fast_num_ff))
    else $error("fast episode declared without full count");
  fast_end_a: assert property ( // see R4
    $fell(fast_rate_episode) && $past(ctrl_ff[`VRED_EN_FAST]) |->
    $past(fast_low_ff) == 3'h4 && $past(beat_iv_v) && !$past(fast_iv))
    else $error("fast episode ended early");
  fast_noise_a: assert property ( // see R5
    fast_rate_episode && noise_window_marker && ctrl_ff[`VRED_EN_FAST]
    |=> $stable(fast_low_ff) && fast_rate_episode)
    else $error("noise changed fast termination");
  fast_floor_a: assert property ( // see R7
    fast_num_ff >= 6'h08) else $error("fast count below floor");
  fast_enable_a: assert property ( // see R8
    !ctrl_ff[`VRED_EN_FAST] |=> !fast_rate_rec ##1 !fast_rate_episode)
    else $error("disabled fast detector active");
  slow_confirm_a: assert property ( // see R10
    slow_rate_rec |-> $past(slow_push) && $past(ssum_push) > $past(dur_ms))
    else $error("slow episode confirmed short");
  slow_noise_a: assert property ( // see R13
    slow_rate_episode && noise_window_marker && ctrl_ff[`VRED_EN_SLOW]
    |=> term_ff == 4'h1) else $error("noise did not set counter to one");
  drop_noise_a: assert property ( // see R18
    noise_window_marker |=> dfill_ff == 10'h0 && !sudden_drop_episode)
    else $error("drop windows kept after noise");
  asys_detect_a: assert property ( // see R20
    asystole_episode |-> $past(beat_iv_v) &&
    $past(iv_ff) > 16'($past(asys_s_ff)) * `VRED_MS_PER_S)
    else $error("asystole without long interval");
  apb_ready_a: assert property (
    psel && penable && !pready |=> pready)
    else $error("apb answer late");

  fast_epi_c: cover property ($rose(fast_rate_episode));
  slow_end_c: cover property ($fell(slow_rate_episode));
  drop_epi_c: cover property (sudden_drop_episode);
  asys_epi_c: cover property (asystole_episode);
endmodule : vred_detector

// file: design/vred_map.svh
// register map, field ranges, reset values and timing counts
`ifndef VRED_MAP_SVH
`define VRED_MAP_SVH
`define VRED_CLK_NS 20
`define VRED_TICK_NS 1000000
`define VRED_MS_PER_MIN 24'd60000
`define VRED_MS_PER_S 16'd1000
`define VRED_PCT_FULL 7'h64
`define VRED_A_CTRL 8'h00
`define VRED_A_FAST 8'h04
`define VRED_A_SLOW 8'h08
`define VRED_A_DROP 8'h0c
`define VRED_A_SENS 8'h10
`define VRED_A_ASYS 8'h14
`define VRED_A_STAT 8'h18
`define VRED_EN_FAST 0
`define VRED_EN_SLOW 1
`define VRED_EN_DROP 2
`define VRED_EN_ASYS 3
`define VRED_F_EN 3:0
`define VRED_F_BPM 7:0
`define VRED_F_FNUM 13:8
`define VRED_F_SDUR 12:8
`define VRED_F_PCT 6:0
`define VRED_F_BSEL 9:8
`define VRED_F_DSEL 11:10
`define VRED_F_SENSRD 13:12
`define VRED_F_SENS 1:0
`define VRED_F_ASYS 3:0
`define VRED_F_DSEEN 2
`define VRED_F_ASEEN 3
`define VRED_F_FCNT 13:8
`define VRED_F_TERM 19:16
`define VRED_CTRL_RST 4'hf
`define VRED_FAST_BPM_RST 8'hb4
`define VRED_FAST_NUM_RST 6'h10
`define VRED_FAST_NUM_MIN 6'h08
`define VRED_FAST_END 3'h4
`define VRED_SLOW_BPM_RST 8'h28
`define VRED_SLOW_DUR_RST 5'h0a
`define VRED_SLOW_END 4'h9
`define VRED_DROP_PCT_RST 7'h32
`define VRED_ASYS_RST 4'h3
`define VRED_SENS_LOW 2'h0
`define VRED_SENS_MED 2'h1
`define VRED_SENS_HIGH 2'h2
`define VRED_SENS_CUST 2'h3
`define VRED_BSEL_48 2'h0
`define VRED_BSEL_64 2'h1
`define VRED_BSEL_128 2'h2
`define VRED_BSEL_256 2'h3
`define VRED_DSEL_8 2'h0
`define VRED_DSEL_16 2'h1
`define VRED_DSEL_32 2'h2
`define VRED_SMEM_FULL 7'h40
`endif

// file: design/vred_pkg.sv
// shared types of the rhythm episode detector
package vred_pkg;
  typedef enum logic [1:0] {VRED_IDLE = 2'b01, VRED_EPI = 2'b10} vred_state_t;
  typedef logic [31:0] vred_word_t;
  typedef logic [7:0] vred_addr_t;
endpackage : vred_pkg

// file: verification/vred_detector_tb.sv
// self-checking bench of the rhythm episode detector
`timescale 1ns/1ns
`include "vred_map.svh"
module vred_detector_tb;
  import vred_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  vred_addr_t paddr = 8'h00;
  vred_word_t pwdata = 32'h0;
  vred_word_t prdata;
  logic pready, pslverr, sb, nw;
  logic fe, frec, se, srec, sde, ase;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  int n_frec = 0;
  int n_srec = 0;
  int n_ase = 0;
  int n_sde = 0;
  vred_word_t rd;
  logic er;
  always #10 pclk = ~pclk;
  vred_detector #(.TICK_CYCLES(4)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sensed_beat_marker(sb), .noise_window_marker(nw),
    .fast_rate_episode(fe), .fast_rate_rec(frec), .slow_rate_episode(se),
    .slow_rate_rec(srec), .sudden_drop_episode(sde),
    .asystole_episode(ase));
  vred_sense_model #(.TICK(4)) u_fe (.pclk(pclk), .sensed_beat_marker(sb),
    .noise_window_marker(nw));
  always @(posedge pclk) begin
    cyc++;
    n_frec += (frec === 1'b1);
    n_srec += (srec === 1'b1);
    n_ase += (ase === 1'b1);
    n_sde += (sde === 1'b1);
    if (cyc == 90000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic chk(input vred_word_t got, input vred_word_t exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // setup, access, then wait for pready; data taken at that edge only
  task automatic apb(input logic w, input vred_addr_t a, input vred_word_t d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input vred_addr_t a, input vred_word_t m,
                      input vred_word_t e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rchk
  task automatic beats(input int n, input int ms);
    repeat (n) begin
      u_fe.gap(ms);
      u_fe.beat();
    end
    repeat (2) @(posedge pclk);
  endtask : beats
  task automatic t_regs();
    rchk(`VRED_A_CTRL, 32'hf, 32'hf);
    rchk(`VRED_A_FAST, 32'h3fff, 32'h10b4);
    rchk(`VRED_A_SLOW, 32'h1fff, 32'h0a28);
    rchk(`VRED_A_DROP, 32'h3fff, 32'h1532);
    apb(1'b1, `VRED_A_FAST, 32'h04b4);
    rchk(`VRED_A_FAST, 32'h3fff, 32'h08b4);
    apb(1'b1, `VRED_A_SENS, 32'h0);
    rchk(`VRED_A_DROP, 32'h3fff, 32'h0b32);
    apb(1'b1, `VRED_A_DROP, 32'h0e32);
    rchk(`VRED_A_DROP, 32'h3fff, 32'h3a32);
    apb(1'b1, `VRED_A_SENS, 32'h2);
    rchk(`VRED_A_DROP, 32'h3fff, 32'h2032);
    apb(1'b1, `VRED_A_DROP, 32'h0632);
    rchk(`VRED_A_SENS, 32'h3, 32'h3);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("test regs done");
  endtask : t_regs
  // noise inside the gap must not restart the beat-to-beat interval
  task automatic t_asys();
    apb(1'b1, `VRED_A_ASYS, 32'h1);
    u_fe.beat();
    u_fe.gap(600);
    u_fe.noise();
    beats(1, 600);
    chk(n_ase, 1);
    rchk(`VRED_A_STAT, 32'h8, 32'h8);
    apb(1'b1, `VRED_A_STAT, 32'h8);
    rchk(`VRED_A_STAT, 32'h8, 32'h0);
    apb(1'b1, `VRED_A_CTRL, 32'h7);
    beats(1, 1200);
    chk(n_ase, 1);
    apb(1'b1, `VRED_A_CTRL, 32'hf);
    $display("test asystole done");
  endtask : t_asys
  task automatic t_fast();
    beats(4, 200);
    rchk(`VRED_A_STAT, 32'h3f00, 32'h0400);
    u_fe.noise();
    rchk(`VRED_A_STAT, 32'h3f00, 32'h0);
    beats(7, 200);
    chk({31'h0, fe}, 32'h0);
    beats(1, 200);
    chk({31'h0, fe}, 32'h1);
    chk(n_frec, 1);
    beats(4, 500);
    u_fe.noise();
    chk({31'h0, fe}, 32'h1);
    beats(1, 500);
    chk({31'h0, fe}, 32'h0);
    $display("test fast done");
  endtask : t_fast
  // 80 bpm limit is 750 ms; 1 s duration needs two 900 ms intervals
  task automatic t_slow();
    apb(1'b1, `VRED_A_SLOW, 32'h0150);
    beats(1, 900);
    chk({31'h0, se}, 32'h0);
    beats(1, 900);
    chk({31'h0, se}, 32'h1);
    chk(n_srec, 1);
    beats(3, 500);
    u_fe.noise();
    rchk(`VRED_A_STAT, 32'hf0000, 32'h10000);
    beats(8, 500);
    rchk(`VRED_A_STAT, 32'hf0002, 32'h90002);
    beats(1, 500);
    chk({31'h0, se}, 32'h0);
    // 2 s run: noise drops both stored intervals, so one more is short
    apb(1'b1, `VRED_A_SLOW, 32'h0250);
    beats(2, 900);
    u_fe.noise();
    beats(1, 900);
    chk({31'h0, se}, 32'h0);
    $display("test slow done");
  endtask : t_slow
  // high preset 48/8: short baseline intervals, then long drop intervals
  task automatic t_drop();
    apb(1'b1, `VRED_A_SENS, 32'h2);
    apb(1'b1, `VRED_A_SENS, 32'h3);
    rchk(`VRED_A_DROP, 32'h3fff, 32'h2032);
    apb(1'b1, `VRED_A_CTRL, 32'h4);
    u_fe.beat();
    u_fe.noise();
    beats(48, 10);
    beats(7, 30);
    u_fe.noise();
    beats(1, 30);
    chk(n_sde, 0);
    u_fe.noise();
    beats(48, 10);
    beats(8, 30);
    chk(n_sde, 1);
    rchk(`VRED_A_STAT, 32'h4, 32'h4);
    $display("test drop done");
  endtask : t_drop
  task automatic stop_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_asys();
    t_fast();
    t_slow();
    t_drop();
    stop_test();
  end
endmodule : vred_detector_tb

// file: verification/vred_sense_model.sv
// sensing front end model driving beat and noise markers
`timescale 1ns/1ns
module vred_sense_model #(
  parameter int TICK = 4
) (
  input wire logic pclk,
  output logic sensed_beat_marker,
  output logic noise_window_marker
);
  initial begin
    sensed_beat_marker = 1'b0;
    noise_window_marker = 1'b0;
  end
  // one-cycle pulse, never together with a noise pulse
  task automatic beat();
    @(posedge pclk);
    sensed_beat_marker <= 1'b1;
    @(posedge pclk);
    sensed_beat_marker <= 1'b0;
  endtask : beat
  // one-cycle pulse, never together with a beat pulse
  task automatic noise();
    @(posedge pclk);
    noise_window_marker <= 1'b1;
    @(posedge pclk);
    noise_window_marker <= 1'b0;
  endtask : noise
  // idle line for ms milliseconds; tick phase jitter is up to one ms
  task automatic gap(input int ms);
    repeat (ms * TICK - 1) @(posedge pclk);
  endtask : gap
endmodule : vred_sense_model
